// ### mode_far_side_model.sv
`timescale 1ns/1ns
module mode_far_side_model #(
  parameter int SLOW_HALF_NS = 817 // Half period of the slow crystal, unrelated to the fast clock.
) (
  input wire logic clk_in, // Fast clock.
  input wire logic pin_req_in, // Pulse: pull the reset pin low.
  output logic reset_n_out, // Reset pin, pulled up when released.
  output logic slow_clk_out // Low-frequency crystal clock.
);
  import mode_reset_pkg::*;
  int hold = 0; // Cycles left with the pin held low.
  // The driver keeps the pin low for the full minimum time, never a cycle less.
  always @(posedge clk_in) begin
    if (pin_req_in) begin
      hold <= PIN_LOW_CYCLES;
    end else if (hold > 0) begin
      hold <= hold - 1;
    end
  end
  // Once released, the pull-up brings the pin back high.
  assign reset_n_out = (hold == 0);
  // The crystal runs free, so its edges drift against the fast clock.
  initial slow_clk_out = 1'b0;
  always #(SLOW_HALF_NS) slow_clk_out = ~slow_clk_out;
endmodule

// ### mode_reset_pkg.sv
package mode_reset_pkg;
  // Register byte offsets on the AHB-Lite slave.
  localparam logic [7:0] SYSCTL_OFFSET = 8'h00;
  localparam logic [7:0] TBCTL_OFFSET = 8'h04;
  localparam logic [7:0] IRQCTL_OFFSET = 8'h08;
  localparam logic [7:0] WDCTL_OFFSET = 8'h0c;
  localparam logic [7:0] STATUS_OFFSET = 8'h10;
  // Field positions in system_control_two.
  localparam int FAST_EN_BIT = 7;
  localparam int SLOW_EN_BIT = 6;
  localparam int CLK_SEL_BIT = 5;
  localparam int HALT_BIT = 2;
  // Field positions in timebase_control.
  localparam int TB_EN_BIT = 3;
  // Field positions in the interrupt control word.
  localparam int IME_BIT = 0;
  localparam int TB_IE_BIT = 1;
  localparam int TB_IL_BIT = 2;
  localparam int TRAP_IL_BIT = 3;
  // Field positions in watchdog_control_one.
  localparam int RAM_TRAP_BIT = 0;
  localparam int TRAP_RESET_BIT = 1;
  localparam int WD_EN_BIT = 2;
  // Values after reset.
  localparam logic [7:0] SYSCTL_RESET = 8'h80;
  localparam logic [3:0] TBCTL_RESET = 4'h0;
  localparam logic [2:0] WDCTL_RESET = 3'h6;
  localparam logic [15:0] RESET_VECTOR = 16'hfffe;
  // Stretched malfunction reset: 24 fast clock periods at most.
  localparam int STRETCH_PERIODS = 24;
  localparam int FC_PERIOD_NS = 100;
  localparam int STRETCH_NS = STRETCH_PERIODS * FC_PERIOD_NS;
  localparam int STRETCH_CYCLES = STRETCH_NS / FC_PERIOD_NS;
  // Pin low time the driver must keep: 12 fast clock periods.
  localparam int PIN_LOW_NS = 12 * FC_PERIOD_NS;
  localparam int PIN_LOW_CYCLES = (PIN_LOW_NS + FC_PERIOD_NS - 1) / FC_PERIOD_NS;
  // Address areas that trap an instruction fetch.
  localparam logic [15:0] SFA_LOW = 16'h0000;
  localparam logic [15:0] SFA_HIGH = 16'h003f;
  localparam logic [15:0] RAM_LOW = 16'h0040;
  localparam logic [15:0] RAM_HIGH = 16'h083f;
  localparam logic [15:0] DBA_LOW = 16'h0f80;
  localparam logic [15:0] DBA_HIGH = 16'h0fff;
  // Operating modes, one-hot.
  typedef enum logic [5:0] {
    SINGLE_CLOCK_RUN = 6'h01,
    DUAL_CLOCK_RUN = 6'h02,
    LOW_CLOCK_RUN = 6'h04,
    LOW_CLOCK_RUN_FAST_OSC_ON = 6'h08,
    DEEP_IDLE_MODE = 6'h10,
    DEEP_SLEEP_MODE = 6'h20
  } op_mode_type;
  // Clock sequencer states, one-hot.
  typedef enum logic [3:0] {
    ST_FAST = 4'h1,
    ST_SLOW = 4'h2,
    ST_SYNC = 4'h4,
    ST_HALT = 4'h8
  } seq_state_type;
endpackage

// ### mode_switch_and_reset_ctrl.sv
// Local design decisions: register access over AHB-Lite and the address map.
`timescale 1ns/1ns
module mode_switch_and_reset_ctrl #(
  parameter int TB_DIV_WIDTH = 8 // Width of the timebase divider.
) (
  input wire logic CLK_IN, // Fast clock, 10 MHz.
  input wire logic SRST_IN, // Power-on reset, active high.
  input wire logic HSEL_IN, // AHB-Lite slave select.
  input wire logic [7:0] HADDR_IN, // AHB-Lite address.
  input wire logic [1:0] HTRANS_IN, // AHB-Lite transfer type.
  input wire logic HWRITE_IN, // AHB-Lite write flag.
  input wire logic [2:0] HSIZE_IN, // AHB-Lite size.
  input wire logic [31:0] HWDATA_IN, // AHB-Lite write data.
  input wire logic HREADY_IN, // AHB-Lite bus ready.
  output logic [31:0] HRDATA_OUT, // AHB-Lite read data.
  output logic HREADYOUT_OUT, // AHB-Lite slave ready.
  output logic HRESP_OUT, // AHB-Lite response.
  input wire logic RESET_N_IN, // External reset pin, active low.
  input wire logic SLOW_CLK_IN, // Low-frequency clock, sampled.
  input wire logic FETCH_VALID_IN, // Core fetch strobe.
  input wire logic [15:0] FETCH_ADDR_IN, // Core fetch address.
  input wire logic WDT_IRQ_IN, // Watchdog interrupt pending.
  input wire logic WDT_RESET_IN, // Watchdog reset request.
  output logic SYS_RESET_OUT, // Internal reset to the core.
  output logic [15:0] RESET_VECTOR_OUT, // Vector address to read.
  output logic VECTOR_FETCH_OUT, // Pulse: fetch reset vector.
  output logic FAST_OSC_EN_OUT, // Fast oscillator enable.
  output logic SLOW_OSC_EN_OUT, // Slow oscillator enable.
  output logic SLOW_CLK_SEL_OUT, // Core runs on the slow clock.
  output logic [5:0] MODE_OUT, // Current operating mode.
  output logic TIMEBASE_TAKE_OUT, // Pulse: timebase irq taken.
  output logic TRAP_IRQ_OUT, // Address trap latch.
  output logic IRQ_MASTER_ENABLE_OUT, // Interrupt master enable.
  output logic WATCHDOG_ENABLE_OUT // Watchdog enable.
);
  import mode_reset_pkg::*;

  logic pin_meta, pin_sync; // Reset pin synchroniser.
  logic slow_meta, slow_sync, slow_prev; // Slow clock synchroniser.
  logic reset_prev; // Internal reset one cycle ago, for the release edge.
  logic stretch_active; // Stretched malfunction reset.
  logic any_reset; // Internal reset from any source.
  logic [7:0] sysctl; // system_control_two.
  logic [3:0] tbctl; // timebase_control.
  logic [3:0] irqctl; // Interrupt enables and latches.
  logic [2:0] wdctl; // watchdog_control_one.
  logic [TB_DIV_WIDTH-1:0] tb_div; // Timebase divider.
  logic tap_prev; // Previous selected tap.
  seq_state_type state; // Clock sequencer.
  logic addr_write; // Captured write address phase.
  logic [7:0] addr_q; // Captured address.
  logic bus_write; // Write data phase completes now.
  logic [7:0] next_sysctl; // Requested system control value.
  logic clock_fault; // Illegal oscillator clear.
  logic trap_hit; // Fetch into trapped area.
  logic tap_fall; // Falling edge of selected tap.
  logic slow_fall; // Falling edge of slow clock.
  logic halt_req; // Software asks for deep halt.
  logic wake; // Halt ends this cycle.
  logic wake_irq; // Wake with interrupt processing.

  // Decode whether a fetch address lies inside an inclusive range.
  function automatic logic in_area(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    in_area = (a >= lo) && (a <= hi);
  endfunction

  // The pin and the slow clock come from outside, so each passes two flops.
  // Only the second flop of each pair is read by the rest of the logic.
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      slow_meta <= 1'b0;
      slow_sync <= 1'b0;
    end else begin
      pin_meta <= RESET_N_IN;
      pin_sync <= pin_meta;
      slow_meta <= SLOW_CLK_IN;
      slow_sync <= slow_meta;
    end
  end

  // Edge history for the internal reset, slow clock and timebase tap.
  // The reset history starts high so power-up also ends in a vector fetch.
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      reset_prev <= 1'b1;
      slow_prev <= 1'b0;
      tap_prev <= 1'b0;
    end else begin
      reset_prev <= any_reset;
      slow_prev <= slow_sync;
      tap_prev <= tb_div[tbctl[2:0]];
    end
  end

  // Falling edges come from the synchronised slow clock and the chosen tap.
  assign slow_fall = slow_prev && !slow_sync;
  assign tap_fall = tap_prev && !tb_div[tbctl[2:0]];

  // Any low level on the pin resets two cycles later, after the synchroniser; the driver keeps it long enough.
  assign any_reset = SRST_IN || !pin_sync || stretch_active;

  // Address trap: special function and data buffer always, RAM on select.
  assign trap_hit = FETCH_VALID_IN && (in_area(FETCH_ADDR_IN, SFA_LOW, SFA_HIGH) ||
                    in_area(FETCH_ADDR_IN, DBA_LOW, DBA_HIGH) ||
                    (wdctl[RAM_TRAP_BIT] && in_area(FETCH_ADDR_IN, RAM_LOW, RAM_HIGH)));

  // Bus write data destined for system control, checked before it lands.
  assign bus_write = addr_write && HREADY_IN;
  assign next_sysctl = HWDATA_IN[7:0];

  // Clearing an oscillator that the core depends on would deadlock it.
  always_comb begin
    clock_fault = 1'b0;
    if (bus_write && addr_q == SYSCTL_OFFSET) begin
      if (!next_sysctl[FAST_EN_BIT] && !next_sysctl[SLOW_EN_BIT] &&
          (sysctl[FAST_EN_BIT] || sysctl[SLOW_EN_BIT])) begin
        clock_fault = 1'b1;
      end else if (sysctl[FAST_EN_BIT] && !next_sysctl[FAST_EN_BIT] && !next_sysctl[CLK_SEL_BIT]) begin
        clock_fault = 1'b1;
      end else if (sysctl[SLOW_EN_BIT] && !next_sysctl[SLOW_EN_BIT] && next_sysctl[CLK_SEL_BIT]) begin
        clock_fault = 1'b1;
      end
    end
  end

  // Three malfunction sources share one stretched pulse.
  // A trap resets only when the trap-reset bit selects it; otherwise it latches.
  reset_stretcher #(
    .CYCLES(STRETCH_CYCLES)
  ) u_stretch (
    .clk_in(CLK_IN),
    .srst_in(SRST_IN),
    .request_in(clock_fault || WDT_RESET_IN || (trap_hit && wdctl[TRAP_RESET_BIT])),
    .active_out(stretch_active)
  );

  // Halt is requested by writing the halt bit; a pending watchdog irq wins.
  assign halt_req = bus_write && addr_q == SYSCTL_OFFSET && next_sysctl[HALT_BIT] &&
                    !WDT_IRQ_IN && !clock_fault;
  assign wake = (state == ST_HALT) && tap_fall;
  assign wake_irq = wake && irqctl[IME_BIT] && irqctl[TB_IE_BIT] && tbctl[TB_EN_BIT];

  // AHB-Lite address phase capture; the slave never inserts wait states.
  // Only writes need the captured phase, since reads are decoded at once.
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      addr_write <= 1'b0;
      addr_q <= 8'h00;
    end else if (HREADY_IN) begin
      addr_write <= HSEL_IN && HTRANS_IN[1] && HWRITE_IN;
      addr_q <= HADDR_IN;
    end
  end

  // Read data is registered at the address phase so it stands from a flop.
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      HRDATA_OUT <= 32'h0000_0000;
    end else if (HREADY_IN && HSEL_IN && HTRANS_IN[1] && !HWRITE_IN) begin
      unique case (HADDR_IN)
        SYSCTL_OFFSET: HRDATA_OUT <= {24'h000000, sysctl};
        TBCTL_OFFSET: HRDATA_OUT <= {28'h0000000, tbctl};
        IRQCTL_OFFSET: HRDATA_OUT <= {28'h0000000, irqctl};
        WDCTL_OFFSET: HRDATA_OUT <= {29'h0, wdctl};
        STATUS_OFFSET: HRDATA_OUT <= {22'h0, state, MODE_OUT};
        default: HRDATA_OUT <= 32'h0000_0000; // Unmapped reads return zero.
      endcase
    end
  end

  // The slave never stalls and never signals an error, so the bus sees OKAY.
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT = 1'b0;

  // System control: software writes, halt bit cleared by hardware on wake.
  always_ff @(posedge CLK_IN) begin
    if (any_reset) begin
      sysctl <= SYSCTL_RESET;
    end else if (bus_write && addr_q == SYSCTL_OFFSET && !clock_fault) begin
      sysctl <= {next_sysctl[7:3], halt_req, 2'b00};
    end else if (wake) begin
      sysctl[HALT_BIT] <= 1'b0;
    end
  end

  // Timebase control and the watchdog control word.
  always_ff @(posedge CLK_IN) begin
    if (any_reset) begin
      tbctl <= TBCTL_RESET;
      wdctl <= WDCTL_RESET;
    end else if (bus_write && addr_q == TBCTL_OFFSET) begin
      tbctl <= HWDATA_IN[3:0];
    end else if (bus_write && addr_q == WDCTL_OFFSET) begin
      wdctl <= HWDATA_IN[2:0];
    end
  end

  // Interrupt enables and latches; hardware sets win over software clears.
  always_ff @(posedge CLK_IN) begin
    if (any_reset) begin
      irqctl <= 4'h0;
    end else begin
      if (bus_write && addr_q == IRQCTL_OFFSET) begin
        irqctl <= HWDATA_IN[3:0] & {irqctl[3:2], 2'b11};
      end
      if (halt_req && tbctl[TB_EN_BIT]) begin
        irqctl[TB_IL_BIT] <= 1'b1;
      end
      if (trap_hit && !wdctl[TRAP_RESET_BIT]) begin
        irqctl[TRAP_IL_BIT] <= 1'b1;
      end
      if (wake_irq) begin
        irqctl[IME_BIT] <= 1'b0;
        irqctl[TB_IL_BIT] <= 1'b0;
      end
    end
  end

  // The divider runs free on the slow clock edges; entering halt does not
  // restart it, so the first wake tap may come early.
  // Widening the divider does not lengthen the longest halt; the three-bit tap select reaches bit 7 only.
  always_ff @(posedge CLK_IN) begin
    if (any_reset) begin
      tb_div <= '0;
    end else if (slow_fall) begin
      tb_div <= tb_div + 1'b1;
    end
  end

  // Clock sequencer: fast run, slow run, synchronising, and deep halt.
  always_ff @(posedge CLK_IN) begin
    if (any_reset) begin
      state <= ST_FAST;
    end else begin
      unique case (state)
        ST_FAST: begin
          if (halt_req) begin
            state <= ST_HALT;
          end else if (sysctl[CLK_SEL_BIT]) begin
            state <= ST_SLOW;
          end
        end
        ST_SLOW: begin
          if (halt_req) begin
            state <= ST_HALT;
          end else if (!sysctl[CLK_SEL_BIT]) begin
            state <= ST_SYNC;
          end
        end
        ST_SYNC: begin
          if (slow_fall) begin
            state <= ST_FAST;
          end
        end
        ST_HALT: begin
          if (wake) begin
            state <= sysctl[CLK_SEL_BIT] ? ST_SLOW : ST_FAST;
          end
        end
        default: state <= ST_FAST;
      endcase
    end
  end

  // Mode report follows the sequencer and the oscillator enables.
  always_comb begin
    MODE_OUT = SINGLE_CLOCK_RUN;
    unique case (state)
      ST_FAST: MODE_OUT = sysctl[SLOW_EN_BIT] ? DUAL_CLOCK_RUN : SINGLE_CLOCK_RUN;
      ST_SLOW, ST_SYNC: MODE_OUT = sysctl[FAST_EN_BIT] ? LOW_CLOCK_RUN_FAST_OSC_ON : LOW_CLOCK_RUN;
      ST_HALT: MODE_OUT = sysctl[CLK_SEL_BIT] ? DEEP_SLEEP_MODE : DEEP_IDLE_MODE;
      default: MODE_OUT = SINGLE_CLOCK_RUN;
    endcase
  end

  // Registered outputs to the core.
  // The vector pulse is high in the second cycle after any reset ends, pin or malfunction.
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      VECTOR_FETCH_OUT <= 1'b0;
      TIMEBASE_TAKE_OUT <= 1'b0;
    end else begin
      VECTOR_FETCH_OUT <= reset_prev && !any_reset;
      TIMEBASE_TAKE_OUT <= wake_irq;
    end
  end

  // Direct views of the control words, except the clock select, which follows the sequencer state; the enables follow software at once.
  assign SYS_RESET_OUT = any_reset;
  assign RESET_VECTOR_OUT = RESET_VECTOR;
  assign FAST_OSC_EN_OUT = sysctl[FAST_EN_BIT];
  assign SLOW_OSC_EN_OUT = sysctl[SLOW_EN_BIT];
  assign SLOW_CLK_SEL_OUT = (state == ST_SLOW) || (state == ST_SYNC) ||
                            ((state == ST_HALT) && sysctl[CLK_SEL_BIT]);
  assign TRAP_IRQ_OUT = irqctl[TRAP_IL_BIT];
  assign IRQ_MASTER_ENABLE_OUT = irqctl[IME_BIT];
  assign WATCHDOG_ENABLE_OUT = wdctl[WD_EN_BIT];

  // Checks on the sequencing and reset behaviour, all in the fast clock domain.
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SRST_IN);
  a_wake_takes_irq: assert property (wake && irqctl[IME_BIT] && irqctl[TB_IE_BIT] && tbctl[TB_EN_BIT]
                                     |=> TIMEBASE_TAKE_OUT && !IRQ_MASTER_ENABLE_OUT)
    else $error("Wake with all enables did not take timebase irq.");
  a_wdt_blocks_halt: assert property (WDT_IRQ_IN && state != ST_HALT |=> state != ST_HALT)
    else $error("Halt entered with watchdog irq pending.");
  a_sync_keeps_slow: assert property (state == ST_SYNC |-> SLOW_CLK_SEL_OUT)
    else $error("Clock changed over before synchronisation.");
  a_pin_restarts_fast: assert property (!pin_sync |=> state == ST_FAST && !sysctl[CLK_SEL_BIT])
    else $error("Pin reset did not restart single clock run.");
  a_reset_clears_irq: assert property (any_reset |=> irqctl == 4'h0 && WATCHDOG_ENABLE_OUT)
    else $error("Reset left interrupt state or watchdog wrong.");
  a_fault_resets: assert property (clock_fault |=> ##[1:2] SYS_RESET_OUT)
    else $error("Oscillator fault gave no clock reset.");
  a_wake_clears_halt: assert property (wake && !any_reset |=> !sysctl[HALT_BIT] && state != ST_HALT)
    else $error("Wake left halt bit or halt state.");
  a_halt_sets_latch: assert property (halt_req && tbctl[TB_EN_BIT] && !any_reset |=> irqctl[TB_IL_BIT])
    else $error("Halt entry with timebase enabled did not set latch.");
  a_trap_to_irq: assert property (trap_hit && !wdctl[TRAP_RESET_BIT] && !any_reset |=> TRAP_IRQ_OUT)
    else $error("Address trap interrupt latch not set.");
  a_release_vector: assert property ($rose(pin_sync) && !stretch_active |=> ##[0:2] VECTOR_FETCH_OUT)
    else $error("Pin release did not fetch the reset vector.");
endmodule

// ### reset_stretcher.sv
`timescale 1ns/1ns
module reset_stretcher #(
  parameter int CYCLES = mode_reset_pkg::STRETCH_CYCLES
) (
  input wire logic clk_in, // Fast clock.
  input wire logic srst_in, // Power-on reset, active high.
  input wire logic request_in, // Malfunction reset request.
  output logic active_out // Stretched reset pulse.
);
  import mode_reset_pkg::*;

  logic [5:0] count; // Cycles of pulse still to run.

  // The counter is cleared only by the power-on reset, never by the pulse it
  // makes itself, so a request during a running pulse reloads the full count.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      count <= 6'h00;
    end else if (request_in) begin
      count <= 6'(CYCLES);
    end else if (count != 6'h00) begin
      count <= count - 6'h01;
    end
  end

  // The pulse is high while cycles remain, so it ends CYCLES cycles after the last request.
  assign active_out = (count != 6'h00);

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  a_pulse_follows_request: assert property (request_in |=> active_out)
    else $error("Malfunction request gave no reset pulse.");
  a_pulse_ends_bounded: assert property (active_out && !request_in |-> ##[0:24] !active_out || request_in)
    else $error("Stretched reset pulse ran too long.");
endmodule

// ### tb_mode_switch_and_reset_ctrl.sv
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module tb_mode_switch_and_reset_ctrl;
  import mode_reset_pkg::*;
  logic clk = 1'b0; // Fast clock.
  logic srst = 1'b1; // Power-on reset.
  logic hsel = 1'b0; // Bus select.
  logic [7:0] haddr = 8'h00; // Bus address.
  logic [1:0] htrans = 2'h0; // Transfer type.
  logic hwrite = 1'b0; // Write flag.
  logic [31:0] hwdata = 32'h0; // Write data.
  logic fetch_v = 1'b0; // Fetch strobe.
  logic [15:0] fetch_a = 16'h0000; // Fetch address.
  logic wdt_irq = 1'b0; // Watchdog interrupt pending.
  logic wdt_rst = 1'b0; // Watchdog reset request.
  logic pin_req = 1'b0; // Asks the pin driver for a reset.
  logic [31:0] hrdata; // Read data.
  logic hready; // Slave ready, fed back as bus ready.
  logic hresp; // Slave response.
  logic pin_n; // Reset pin level.
  logic slow_clk; // Slow crystal clock.
  logic sys_rst; // Internal reset.
  logic [15:0] vector; // Reset vector address.
  logic vec_fetch; // Vector fetch pulse.
  logic fast_en; // Fast oscillator enable.
  logic slow_en; // Slow oscillator enable.
  logic slow_sel; // Core on the slow clock.
  logic [5:0] mode; // Operating mode.
  logic tb_take; // Timebase interrupt taken.
  logic trap; // Address trap latch.
  logic ime; // Interrupt master enable.
  logic wd_en; // Watchdog enable.
  int n_mismatch = 0; // Mismatches seen.
  int compares = 0; // Comparisons made.
  int cycles = 0; // Cycles run, for the hang guard.

  mode_switch_and_reset_ctrl u_mode_switch_and_reset_ctrl (
    .CLK_IN(clk), .SRST_IN(srst), .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans),
    .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hready),
    .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .RESET_N_IN(pin_n),
    .SLOW_CLK_IN(slow_clk), .FETCH_VALID_IN(fetch_v), .FETCH_ADDR_IN(fetch_a),
    .WDT_IRQ_IN(wdt_irq), .WDT_RESET_IN(wdt_rst), .SYS_RESET_OUT(sys_rst),
    .RESET_VECTOR_OUT(vector), .VECTOR_FETCH_OUT(vec_fetch), .FAST_OSC_EN_OUT(fast_en),
    .SLOW_OSC_EN_OUT(slow_en), .SLOW_CLK_SEL_OUT(slow_sel), .MODE_OUT(mode),
    .TIMEBASE_TAKE_OUT(tb_take), .TRAP_IRQ_OUT(trap), .IRQ_MASTER_ENABLE_OUT(ime),
    .WATCHDOG_ENABLE_OUT(wd_en));
  mode_far_side_model u_mode_far_side_model (.clk_in(clk), .pin_req_in(pin_req),
    .reset_n_out(pin_n), .slow_clk_out(slow_clk));

  // Fast clock at 10 MHz.
  always #50 clk = ~clk;
  // A hang is cut short here; the limit is well above the full sequence.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_mismatch++;
      results();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Single word transfer; the master waits on ready in both phases.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] v);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    v = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    xfer(1'b1, a, d, v);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    xfer(1'b0, a, 32'h0, v);
  endtask
  task automatic fetch(input logic [15:0] a);
    fetch_v <= 1'b1;
    fetch_a <= a;
    cyc(1);
    fetch_v <= 1'b0;
    cyc(1);
  endtask
  // Measures one internal reset pulse and counts vector fetch pulses after it.
  task automatic rst_len(output int n, output int p);
    int k;
    k = 0;
    while (sys_rst !== 1'b1 && k < 20) begin
      @(posedge clk);
      k++;
    end
    n = 0;
    while (sys_rst === 1'b1 && n < 80) begin
      @(posedge clk);
      n++;
    end
    p = 0;
    repeat (4) begin
      @(posedge clk);
      if (vec_fetch === 1'b1) p++;
    end
  endtask

  task automatic t_reset_values();
    logic [31:0] v;
    rd(IRQCTL_OFFSET, v); `CHK("irqctl", 32'h0, v)
    rd(SYSCTL_OFFSET, v); `CHK("sysctl", {24'h0, SYSCTL_RESET}, v)
    rd(WDCTL_OFFSET, v); `CHK("wdctl", {29'h0, WDCTL_RESET}, v)
    rd(8'h14, v); `CHK("unmapped", 32'h0, v)
    `CHK("vector", 16'hfffe, vector)
    `CHK("mode", SINGLE_CLOCK_RUN, mode)
    `CHK("ime", 1'b0, ime)
    `CHK("wd_en", 1'b1, wd_en)
    `CHK("fast_en", 1'b1, fast_en)
    `CHK("slow_en", 1'b0, slow_en)
    `CHK("hresp", 1'b0, hresp)
  endtask
  // Dual to low clock and back, software keeping the documented order.
  task automatic t_slow_switch();
    logic [31:0] v;
    int n;
    wr(SYSCTL_OFFSET, 32'hc0);
    cyc(1); `CHK("dual", DUAL_CLOCK_RUN, mode)
    wr(SYSCTL_OFFSET, 32'he0);
    cyc(2); `CHK("low fast on", LOW_CLOCK_RUN_FAST_OSC_ON, mode)
    // Fast oscillator stopped here, as it must be before any stop mode.
    wr(SYSCTL_OFFSET, 32'h60);
    cyc(1); `CHK("low", LOW_CLOCK_RUN, mode)
    `CHK("low fast en", 1'b0, fast_en)
    `CHK("low slow en", 1'b1, slow_en)
    rd(STATUS_OFFSET, v); `CHK("status", {22'h0, ST_SLOW, LOW_CLOCK_RUN}, v)
    wr(SYSCTL_OFFSET, 32'he0);
    cyc(20);
    wr(SYSCTL_OFFSET, 32'hc0);
    n = 0;
    while (slow_sel === 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    `CHK("sync wait", 1'b1, (n >= 3 && n <= 40))
    cyc(1); `CHK("dual back", DUAL_CLOCK_RUN, mode)
  endtask
  // Each illegal oscillator clear gives a short reset back to single clock.
  task automatic t_clock_reset();
    logic [7:0] pre [3] = '{8'hc0, 8'hc0, 8'he0};
    logic [7:0] bad [3] = '{8'h00, 8'h40, 8'ha0};
    int n;
    int p;
    for (int i = 0; i < 3; i++) begin
      wr(SYSCTL_OFFSET, {24'h0, pre[i]});
      wr(SYSCTL_OFFSET, {24'h0, bad[i]});
      rst_len(n, p);
      `CHK("clk reset len", 1'b1, (n >= 1 && n <= 24))
      `CHK("clk reset mode", SINGLE_CLOCK_RUN, mode)
      `CHK("clk reset vector", 1, p)
    end
    wdt_rst <= 1'b1;
    cyc(1);
    wdt_rst <= 1'b0;
    rst_len(n, p); `CHK("wd reset len", 1'b1, (n >= 1 && n <= 24))
    `CHK("wd reset vector", 1, p)
  endtask
  task automatic t_trap();
    int n;
    int p;
    wr(WDCTL_OFFSET, 32'h4);
    fetch(16'h0100); `CHK("ram open", 1'b0, trap)
    fetch(16'h0fa0); `CHK("buffer trap", 1'b1, trap)
    wr(IRQCTL_OFFSET, 32'h0);
    cyc(1); `CHK("trap cleared", 1'b0, trap)
    wr(WDCTL_OFFSET, 32'h5);
    fetch(16'h0100); `CHK("ram trap", 1'b1, trap)
    wr(WDCTL_OFFSET, 32'h6);
    fetch(16'h0020);
    rst_len(n, p); `CHK("trap reset len", 1'b1, (n >= 1 && n <= 24))
    `CHK("trap reset vector", 1, p)
  endtask
  // Pin reset in low clock run restarts single clock at the vector.
  task automatic t_pin();
    int n;
    int p;
    wr(SYSCTL_OFFSET, 32'he0);
    wr(SYSCTL_OFFSET, 32'h60);
    wr(IRQCTL_OFFSET, 32'h3);
    pin_req <= 1'b1;
    cyc(1);
    pin_req <= 1'b0;
    rst_len(n, p);
    `CHK("pin reset", 1'b1, (n >= 12))
    `CHK("vector pulse", 1, p)
    `CHK("pin mode", SINGLE_CLOCK_RUN, mode)
    `CHK("pin ime", 1'b0, ime)
  endtask
  // Halt entry, the watchdog block, and wake with and without interrupt.
  task automatic t_halt();
    logic [31:0] v;
    int n;
    int t;
    wr(SYSCTL_OFFSET, 32'hc0);
    wr(TBCTL_OFFSET, 32'ha);
    wr(IRQCTL_OFFSET, 32'h3);
    wdt_irq <= 1'b1;
    wr(SYSCTL_OFFSET, 32'hc4);
    cyc(1); `CHK("halt blocked", DUAL_CLOCK_RUN, mode)
    wdt_irq <= 1'b0;
    wr(SYSCTL_OFFSET, 32'hc4);
    cyc(1); `CHK("deep idle", DEEP_IDLE_MODE, mode)
    n = 0;
    while (tb_take !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    `CHK("take", 1'b1, tb_take)
    cyc(1); `CHK("wake mode", DUAL_CLOCK_RUN, mode)
    `CHK("wake ime", 1'b0, ime)
    rd(SYSCTL_OFFSET, v); `CHK("halt bit", 32'hc0, v)
    wr(IRQCTL_OFFSET, 32'h2);
    wr(SYSCTL_OFFSET, 32'he4);
    cyc(1); `CHK("deep sleep", DEEP_SLEEP_MODE, mode)
    n = 0;
    t = 0;
    while (mode === DEEP_SLEEP_MODE && n < 400) begin
      @(posedge clk);
      n++;
      if (tb_take === 1'b1) t++;
    end
    cyc(2); `CHK("no take", 0, t)
    `CHK("sleep wake", LOW_CLOCK_RUN_FAST_OSC_ON, mode)
    rd(IRQCTL_OFFSET, v); `CHK("tb latch", 32'h6, v)
  endtask

  task automatic results();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Main sequence: reset, then every scenario in turn.
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    cyc(6);
    t_reset_values();
    t_slow_switch();
    t_clock_reset();
    t_trap();
    t_pin();
    t_halt();
    results();
  end
endmodule
